// [bench/tc_chk.sv]
`timescale 1ns/1ps
`include "tc_map.svh"
// ----------------------------------------
// port checks of the capture unit
// ----------------------------------------
module tc_chk
   import tc_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        sample_req,
   input wire logic [1:0]  capture_state
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic wr_st;
   assign acc   = psel && penable && pready;
   assign wr_st = acc && pwrite && paddr == `TC_OFF_STATE;
   a_ready_wait: assert property ($rose(penable) && psel |=> pready) else $error("pready late");
   a_ready_early: assert property ($rose(penable) && psel |-> !pready) else $error("pready early");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
   a_err_unaligned: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr) else $error("no pslverr");
   a_err_rdzero: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
   a_clr_rdzero: assert property (acc && !pwrite && paddr == `TC_OFF_ICLR |-> prdata == 32'h0)
      else $error("clear reg read");
   a_stop_idle: assert property (wr_st && pwdata == 32'h0 |=> capture_state == TC_IDLE)
      else $error("stop ignored");
   a_idle_noreq: assert property (capture_state == TC_IDLE && $past(capture_state) == TC_IDLE |-> !sample_req)
      else $error("request in idle");
   a_cont_stays: assert property (capture_state == TC_CONT && !wr_st |=> capture_state == TC_CONT)
      else $error("continuous left");
   a_post_idle: assert property (capture_state == TC_POST && !wr_st |=> capture_state inside {TC_POST, TC_IDLE})
      else $error("post order");
endmodule : tc_chk
bind tc_capture tc_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .sample_req(sample_req), .capture_state(capture_state));

// [bench/tc_fetch.sv]
`timescale 1ns/1ps
// ----------------------------------------
// sample fetcher: ramp source, prompt or slow
// ----------------------------------------
module tc_fetch (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        sample_req,
   input  wire logic        slow,
   input  wire logic        clr,
   input  wire logic        neg,
   output logic             sample_valid,
   output logic [63:0]      sample_data,
   output logic [31:0]      trig_value
);
   logic [31:0] n_q;
   logic [3:0]  dly_q;
   logic        pend_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_q          <= '0;
         dly_q        <= '0;
         pend_q       <= 1'b0;
         sample_valid <= 1'b0;
         sample_data  <= '0;
         trig_value   <= '0;
      end else begin
         sample_valid <= 1'b0;
         // stale data is inverted so nothing can pass on a leftover value
         sample_data  <= ~sample_data;
         trig_value   <= ~trig_value;
         if (clr) begin
            n_q <= '0;
         end
         if (sample_req) begin
            pend_q <= 1'b1;
            dly_q  <= slow ? 4'h6 : 4'h0;
         end else if (pend_q && dly_q != 4'h0) begin
            dly_q <= dly_q - 4'h1;
         end else if (pend_q) begin
            pend_q       <= 1'b0;
            sample_valid <= 1'b1;
            sample_data  <= {~n_q, n_q};
            trig_value   <= neg ? -(n_q * 32'd10) : n_q * 32'd10;
            n_q          <= n_q + 32'd1;
         end
      end
   end
endmodule : tc_fetch

// [bench/testbench.sv]
`timescale 1ns/1ps
`include "tc_map.svh"
module testbench
   import tc_pkg::*;
;
   typedef struct packed {logic e; logic [31:0] m; logic [31:0] d;} tc_exp_t;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err_log = 0;
   logic [7:0] paddr = '0, err_mode = '0, err_pwm = '0;
   logic [31:0] pwdata = '0, prdata, trig_value, trig_source_sel, err_speed = '0, r = 32'h1c84;
   logic [15:0] err_word = '0, err_vbus = '0, err_current = '0, err_temp = '0;
   logic pready, pslverr, irq, sample_req, sample_valid, slow = 0, clr = 1, neg = 0, seen_post = 0;
   logic [63:0] sample_data;
   logic [5:0][31:0] chan_select, cs;
   logic [1:0] capture_state;
   logic [127:0] rec [9];
   tc_exp_t exp_q[$], ex;
   int fail_count = 0, checks = 0, nval = 0;
   tc_capture i_tc_capture (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
      .sample_req(sample_req), .sample_valid(sample_valid), .sample_data(sample_data),
      .trig_value(trig_value), .chan_select(chan_select), .trig_source_sel(trig_source_sel),
      .capture_state(capture_state), .err_log(err_log), .err_word(err_word), .err_vbus(err_vbus),
      .err_speed(err_speed), .err_current(err_current), .err_temp(err_temp), .err_mode(err_mode),
      .err_pwm(err_pwm));
   tc_fetch i_tc_fetch (.pclk(pclk), .presetn(presetn), .sample_req(sample_req), .slow(slow), .clr(clr),
      .neg(neg), .sample_valid(sample_valid), .sample_data(sample_data), .trig_value(trig_value));
   always #10 pclk = ~pclk;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask : cmp
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test
   // ----------------------------------------
   // apb master and result watcher
   // ----------------------------------------
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic e);
      int n;
      exp_q.push_back({e, m, w ? 32'h0 : d});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= w ? d : r;
      @(posedge pclk);
      penable <= 1'b1;
      // no fixed latency assumed: pready is taken as it stood at each rising edge
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) cmp("pready", 32'h1, {31'h0, pready});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 32'h0, 1'b0);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      xfer(1'b0, a, d, m, 1'b0);
   endtask : rd
   always @(negedge pclk) begin
      if (capture_state === TC_POST) seen_post <= 1'b1;
      if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
         ex = exp_q.pop_front();
         cmp("pslverr", {31'h0, ex.e}, {31'h0, pslverr});
         cmp("prdata", ex.d & ex.m, prdata & ex.m);
      end
   end
   always @(posedge pclk) if (sample_valid === 1'b1) nval <= nval + 1;
   task automatic settle;
      repeat (3) @(posedge pclk);
   endtask : settle
   task automatic run_cap(input logic [7:0] f, input logic [31:0] lv, input logic [15:0] pre,
                          input logic [15:0] cnt, input logic ng);
      clr <= 1'b1;
      neg <= ng;
      slow <= ng;
      wr(`TC_OFF_ICLR, 32'hf);
      wr(`TC_OFF_FLAGS, {24'h0, f});
      wr(`TC_OFF_LEVEL, lv);
      wr(`TC_OFF_PRETRIG, {16'h0, pre});
      clr <= 1'b0;
      wr(`TC_OFF_COUNT, {16'h0, cnt});
      wr(`TC_OFF_STATE, 32'h1);
      cmp("start", (pre == 16'hffff) ? 32'h2 : 32'h1, {30'h0, capture_state});
   endtask : run_cap
   task automatic wait_end(input int t);
      int n;
      for (n = 0; n < 40000 && (t < 0 ? capture_state !== TC_IDLE : nval < t); n++) @(negedge pclk);
      if (n == 40000) cmp("wait", 32'h0, 32'h1);
   endtask : wait_end
   task automatic buf_chk(input int i, input logic [31:0] v);
      wr(`TC_OFF_BIDX, i);
      rd(`TC_OFF_BLO, v, '1);
      rd(`TC_OFF_BHI, ~v, '1);
   endtask : buf_chk
   initial begin
      #(80000 * 20);
      fail_count++;
      end_of_test();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`TC_OFF_INTERVAL, 32'h1, '1);
      rd(`TC_OFF_PRETRIG, 32'h0, '1);
      rd(`TC_OFF_COUNT, 32'h64, '1);
      rd(`TC_OFF_MASK, 32'hffffffff, '1);
      rd(`TC_OFF_STATE, 32'h0, '1);
      rd(`TC_OFF_ICLR, 32'h0, '1);
      xfer(1'b0, 8'h64, 32'h0, '1, 1'b1);
      xfer(1'b0, 8'h02, 32'h0, '1, 1'b1);
      xfer(1'b1, 8'h02, 32'h5, 32'h0, 1'b1);
      cmp("refused write", 32'h0, chan_select[0]);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         r = lfsr(r);
         cs[i] = {r[31:8], 8'h08};
         wr(8'(4 * i), cs[i]);
         rd(8'(4 * i), cs[i], '1);
         cmp("chan_select", cs[i], chan_select[i]);
      end
      r = lfsr(r);
      wr(`TC_OFF_SRC, r);
      cmp("trig_source_sel", r, trig_source_sel);
      wr(`TC_OFF_CH0, {cs[0][31:8], 8'h30});
      wr(`TC_OFF_IEN, 32'h4);
      wr(`TC_OFF_STATE, 32'h1);
      settle();
      cmp("refused", 32'h0, {30'h0, capture_state});
      cmp("irq", 32'h1, {31'h0, irq});
      wr(`TC_OFF_IEN, 32'h0);
      settle();
      cmp("irq masked", 32'h0, {31'h0, irq});
      wr(`TC_OFF_IEN, 32'h4);
      wr(`TC_OFF_ICLR, 32'h4);
      settle();
      cmp("irq clear", 32'h0, {31'h0, irq});
      wr(`TC_OFF_CH0, {cs[0][31:8], 8'h18});
      wr(`TC_OFF_STATE, 32'h1);
      cmp("sum 64", 32'h1, {30'h0, capture_state});
      wr(`TC_OFF_STATE, 32'h0);
      $display("test config done");
      run_cap(8'h1, 32'd15, 16'h1, 16'h4, 1'b0);
      wait_end(-1);
      cmp("post seen", 32'h1, {31'h0, seen_post});
      rd(`TC_OFF_ISTAT, 32'h3, 32'h3);
      for (int i = 0; i < 4; i++) buf_chk(i, 32'(i + 1));
      run_cap(8'h0, -32'sd15, 16'h0, 16'h2, 1'b1);
      wait_end(-1);
      buf_chk(0, 32'h2);
      // the mask lifts the second sample over the level, so the trigger comes one sample early
      wr(`TC_OFF_MASK, 32'hffffff00);
      run_cap(8'h7, 32'd15, 16'hffff, 16'h2, 1'b1);
      wait_end(nval + 6);
      cmp("still running", 32'h2, {30'h0, capture_state});
      rd(`TC_OFF_ISTAT, 32'h2, 32'h2);
      wr(`TC_OFF_STATE, 32'h0);
      buf_chk(0, 32'h1);
      $display("test capture done");
      for (int k = 0; k < 9; k++) begin
         for (int w = 0; w < 4; w++) begin
            r = lfsr(r);
            rec[k][32*w+:32] = r;
         end
         rec[k][127:112] = 16'h0;
         {err_mode, err_pwm, err_current, err_temp, err_speed, err_vbus, err_word} <= rec[k][111:0];
         err_log <= 1'b1;
         @(posedge pclk);
         err_log <= 1'b0;
         @(posedge pclk);
      end
      rd(`TC_OFF_ISTAT, 32'h8, 32'h8);
      for (int j = 0; j < 8; j += 7) begin
         wr(`TC_OFF_EIDX, j);
         for (int w = 0; w < 4; w++) rd(8'(`TC_OFF_EW0 + 4 * w), rec[8-j][32*w+:32], '1);
      end
      $display("test history done");
      end_of_test();
   end
endmodule : testbench

// [inc/tc_map.svh]
`ifndef TC_MAP_SVH
`define TC_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TC_OFF_CH0      8'h00
`define TC_OFF_STATE    8'h18
`define TC_OFF_INTERVAL 8'h1c
`define TC_OFF_PRETRIG  8'h20
`define TC_OFF_COUNT    8'h24
`define TC_OFF_FLAGS    8'h28
`define TC_OFF_SRC      8'h2c
`define TC_OFF_LEVEL    8'h30
`define TC_OFF_MASK     8'h34
`define TC_OFF_ISTAT    8'h38
`define TC_OFF_ICLR     8'h3c
`define TC_OFF_IEN      8'h40
`define TC_OFF_BIDX     8'h44
`define TC_OFF_BLO      8'h48
`define TC_OFF_BHI      8'h4c
`define TC_OFF_EIDX     8'h50
`define TC_OFF_EW0      8'h54
`define TC_OFF_EW1      8'h58
`define TC_OFF_EW2      8'h5c
`define TC_OFF_EW3      8'h60
// ----------------------------------------
// field positions
// ----------------------------------------
`define TC_SEL_IDX_MSB  31
`define TC_SEL_IDX_LSB  16
`define TC_SEL_SUB_MSB  15
`define TC_SEL_SUB_LSB  8
`define TC_SEL_LEN_MSB  7
`define TC_SEL_LEN_LSB  0
`define TC_FLG_RISE     0
`define TC_FLG_ABS      1
`define TC_FLG_MASK     2
`define TC_IRQ_DONE     0
`define TC_IRQ_TRIG     1
`define TC_IRQ_CFG      2
`define TC_IRQ_ERR      3
`define TC_NIRQ         4
// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define TC_NCH          6
`define TC_MAX_BITS     10'd64
`define TC_DEPTH        256
`define TC_AW           8
`define TC_HIST         8
`define TC_CONT_PRE     16'hffff
`define TC_RST_COUNT    16'h0064
`define TC_RST_MASK     32'hffffffff
`define TC_RST_INTERVAL 16'h0001
// ----------------------------------------
// timing
// ----------------------------------------
`define TC_CLK_NS       20
`define TC_BASE_NS      62500
`define TC_BASE_CYC     (`TC_BASE_NS / `TC_CLK_NS)
`endif

// [inc/tc_pkg.sv]
package tc_pkg;
   typedef enum logic [1:0] {
      TC_IDLE = 2'b00,
      TC_PRE  = 2'b01,
      TC_CONT = 2'b10,
      TC_POST = 2'b11
   } tc_state_t;
endpackage : tc_pkg

// [src/tc_capture.sv]
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "tc_map.svh"
module tc_capture
   import tc_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   output logic                      irq,
   output logic                      sample_req,
   input  wire logic                 sample_valid,
   input  wire logic [63:0]          sample_data,
   input  wire logic [31:0]          trig_value,
   output logic [`TC_NCH-1:0][31:0]  chan_select,
   output logic [31:0]               trig_source_sel,
   output logic [1:0]                capture_state,
   input  wire logic                 err_log,
   input  wire logic [15:0]          err_word,
   input  wire logic [15:0]          err_vbus,
   input  wire logic [31:0]          err_speed,
   input  wire logic [15:0]          err_current,
   input  wire logic [15:0]          err_temp,
   input  wire logic [7:0]           err_mode,
   input  wire logic [7:0]           err_pwm
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   tc_state_t               state_q;
   logic [15:0]             interval_q;
   logic [15:0]             pretrig_q;
   logic [15:0]             count_q;
   logic [7:0]              flags_q;
   logic [31:0]             level_q;
   logic [31:0]             mask_q;
   logic [`TC_NIRQ-1:0]     istat_q;
   logic [`TC_NIRQ-1:0]     ien_q;
   logic [`TC_AW-1:0]       bidx_q;
   logic [2:0]              eidx_q;
   logic [31:0]             rdata_d;
   logic                    rerr_d;
   logic                    acc;
   logic                    wr_en;
   logic                    rd_en;
   logic [63:0]             mem [0:`TC_DEPTH-1];
   logic [`TC_AW-1:0]       wr_ptr_q;
   logic [`TC_AW-1:0]       base_q;
   logic [8:0]              stored_q;
   logic [8:0]              fill_q;
   logic                    saving_q;
   logic                    above_q;
   logic                    prev_ok_q;
   logic [11:0]             base_cnt_q;
   logic [15:0]             int_cnt_q;
   logic [127:0]            hist_q [0:`TC_HIST-1];
   logic [9:0]              len_sum [0:`TC_NCH];
   logic                    cfg_bad;
   logic [8:0]              eff_count;
   logic [8:0]              pre_n;
   logic [31:0]             tval;
   logic                    above;
   logic                    fire;
   logic                    running;
   logic                    ev_done;
   logic                    ev_trig;
   logic                    ev_cfg;
   logic                    start_wr;
   logic                    store;
   logic [`TC_NIRQ-1:0]     ev_vec;

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   // one wait state: the answer is registered so prdata comes from a flop
   assign acc   = psel & penable;
   assign wr_en = acc & pready & pwrite;
   assign rd_en = acc & ~pready & ~pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= acc & ~pready;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (acc & ~pready) begin
         prdata  <= rd_en ? rdata_d : 32'h0000_0000;
         pslverr <= rerr_d;
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      rerr_d  = 1'b0;
      if (paddr[1:0] != 2'b00) begin
         rerr_d = 1'b1;
      end else if (paddr < `TC_OFF_STATE) begin
         rdata_d = chan_select[paddr[4:2]];
      end else begin
         case (paddr)
            `TC_OFF_STATE:    rdata_d = {30'h0, state_q};
            `TC_OFF_INTERVAL: rdata_d = {16'h0, interval_q};
            `TC_OFF_PRETRIG:  rdata_d = {16'h0, pretrig_q};
            `TC_OFF_COUNT:    rdata_d = {16'h0, count_q};
            `TC_OFF_FLAGS:    rdata_d = {24'h0, flags_q};
            `TC_OFF_SRC:      rdata_d = trig_source_sel;
            `TC_OFF_LEVEL:    rdata_d = level_q;
            `TC_OFF_MASK:     rdata_d = mask_q;
            `TC_OFF_ISTAT:    rdata_d = {28'h0, istat_q};
            `TC_OFF_ICLR:     rdata_d = 32'h0000_0000;
            `TC_OFF_IEN:      rdata_d = {28'h0, ien_q};
            `TC_OFF_BIDX:     rdata_d = {24'h0, bidx_q};
            `TC_OFF_BLO:      rdata_d = mem[base_q + bidx_q][31:0];
            `TC_OFF_BHI:      rdata_d = mem[base_q + bidx_q][63:32];
            `TC_OFF_EIDX:     rdata_d = {29'h0, eidx_q};
            `TC_OFF_EW0:      rdata_d = hist_q[eidx_q][31:0];
            `TC_OFF_EW1:      rdata_d = hist_q[eidx_q][63:32];
            `TC_OFF_EW2:      rdata_d = hist_q[eidx_q][95:64];
            `TC_OFF_EW3:      rdata_d = hist_q[eidx_q][127:96];
            default:          rerr_d  = 1'b1;
         endcase
      end
   end

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_select     <= '0;
         interval_q      <= `TC_RST_INTERVAL;
         pretrig_q       <= 16'h0000;
         count_q         <= `TC_RST_COUNT;
         flags_q         <= 8'h00;
         trig_source_sel <= 32'h0000_0000;
         level_q         <= 32'h0000_0000;
         mask_q          <= `TC_RST_MASK;
         ien_q           <= '0;
         bidx_q          <= '0;
         eidx_q          <= 3'h0;
      end else if (wr_en) begin
         if (paddr < `TC_OFF_STATE && paddr[1:0] == 2'b00) begin
            chan_select[paddr[4:2]] <= pwdata;
         end
         case (paddr)
            `TC_OFF_INTERVAL: interval_q      <= pwdata[15:0];
            `TC_OFF_PRETRIG:  pretrig_q       <= pwdata[15:0];
            `TC_OFF_COUNT:    count_q         <= pwdata[15:0];
            `TC_OFF_FLAGS:    flags_q         <= pwdata[7:0];
            `TC_OFF_SRC:      trig_source_sel <= pwdata;
            `TC_OFF_LEVEL:    level_q         <= pwdata;
            `TC_OFF_MASK:     mask_q          <= pwdata;
            `TC_OFF_IEN:      ien_q           <= pwdata[`TC_NIRQ-1:0];
            `TC_OFF_BIDX:     bidx_q          <= pwdata[`TC_AW-1:0];
            `TC_OFF_EIDX:     eidx_q          <= pwdata[2:0];
            default:          ;
         endcase
      end
   end

   // ----------------------------------------
   // channel length check
   // ----------------------------------------
   assign len_sum[0] = 10'd0;
   genvar gi;
   generate
      for (gi = 0; gi < `TC_NCH; gi = gi + 1) begin : g_len
         assign len_sum[gi+1] = len_sum[gi] + {2'b00, chan_select[gi][`TC_SEL_LEN_MSB:`TC_SEL_LEN_LSB]};
      end
   endgenerate
   // a zero length marks a disabled channel and adds nothing
   assign cfg_bad = len_sum[`TC_NCH] > `TC_MAX_BITS;

   // ----------------------------------------
   // sample timebase
   // ----------------------------------------
   // base tick every 62.5 us, then the programmed interval; zero acts as one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_cnt_q <= 12'h000;
         int_cnt_q  <= 16'h0000;
         sample_req <= 1'b0;
      end else begin
         sample_req <= 1'b0;
         if (!running) begin
            base_cnt_q <= 12'h000;
            int_cnt_q  <= 16'h0000;
         end else if (base_cnt_q == 12'(`TC_BASE_CYC - 1)) begin
            base_cnt_q <= 12'h000;
            if (int_cnt_q + 16'h0001 >= interval_q) begin
               int_cnt_q  <= 16'h0000;
               sample_req <= 1'b1;
            end else begin
               int_cnt_q <= int_cnt_q + 16'h0001;
            end
         end else begin
            base_cnt_q <= base_cnt_q + 12'h001;
         end
      end
   end

   // ----------------------------------------
   // trigger detection
   // ----------------------------------------
   always_comb begin
      tval = trig_value;
      if (flags_q[`TC_FLG_MASK]) begin
         tval = trig_value & mask_q;
      end
      // the most negative value has no positive twin and stays negative
      if (flags_q[`TC_FLG_ABS] && tval[31]) begin
         tval = 32'h0000_0000 - tval;
      end
   end

   assign above = $signed(tval) > $signed(level_q);
   assign fire  = store & prev_ok_q &
                  (flags_q[`TC_FLG_RISE] ? (~above_q & above) : (above_q & ~above));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         above_q   <= 1'b0;
         prev_ok_q <= 1'b0;
      end else if (start_wr || !running) begin
         prev_ok_q <= 1'b0;
      end else if (store) begin
         above_q   <= above;
         prev_ok_q <= 1'b1;
      end
   end

   // ----------------------------------------
   // capture control
   // ----------------------------------------
   assign running   = state_q != TC_IDLE;
   assign store     = running & sample_valid;
   assign start_wr  = wr_en & (paddr == `TC_OFF_STATE);
   // count is clipped to the buffer depth; zero still stores one sample
   assign eff_count = (count_q == 16'h0000) ? 9'd1 :
                      (count_q > 16'(`TC_DEPTH)) ? 9'(`TC_DEPTH) : count_q[8:0];
   assign pre_n     = pretrig_q[15] ? 9'd0 :
                      (pretrig_q >= {7'h0, eff_count}) ? eff_count - 9'd1 : pretrig_q[8:0];
   assign capture_state = state_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q  <= TC_IDLE;
         wr_ptr_q <= '0;
         base_q   <= '0;
         stored_q <= 9'd0;
         fill_q   <= 9'd0;
         saving_q <= 1'b0;
      end else if (start_wr) begin
         wr_ptr_q <= '0;
         fill_q   <= 9'd0;
         stored_q <= 9'd0;
         saving_q <= 1'b0;
         if (pwdata[7:0] == 8'h00 || cfg_bad) begin
            state_q <= TC_IDLE;
         end else if (pretrig_q == `TC_CONT_PRE) begin
            state_q <= TC_CONT;
         end else begin
            state_q <= TC_PRE;
         end
      end else if (store) begin
         case (state_q)
            TC_PRE: begin
               mem[wr_ptr_q] <= sample_data;
               wr_ptr_q      <= wr_ptr_q + 1'b1;
               if (fire && fill_q == pre_n) begin
                  base_q   <= wr_ptr_q - fill_q[`TC_AW-1:0];
                  stored_q <= fill_q + 9'd1;
                  state_q  <= (fill_q + 9'd1 == eff_count) ? TC_IDLE : TC_POST;
               end else if (fill_q != pre_n) begin
                  fill_q <= fill_q + 9'd1;
               end
            end
            TC_POST: begin
               mem[wr_ptr_q] <= sample_data;
               wr_ptr_q      <= wr_ptr_q + 1'b1;
               stored_q      <= stored_q + 9'd1;
               if (stored_q + 9'd1 == eff_count) begin
                  state_q <= TC_IDLE;
               end
            end
            TC_CONT: begin
               // stays in this state until software writes the state register
               if (saving_q || fire) begin
                  mem[wr_ptr_q] <= sample_data;
                  wr_ptr_q      <= wr_ptr_q + 1'b1;
                  if (!saving_q) begin
                     base_q   <= wr_ptr_q;
                     stored_q <= 9'd1;
                     saving_q <= eff_count != 9'd1;
                  end else begin
                     stored_q <= stored_q + 9'd1;
                     if (stored_q + 9'd1 == eff_count) begin
                        saving_q <= 1'b0;
                     end
                  end
               end
            end
            default: state_q <= TC_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // error history
   // ----------------------------------------
   // entry 0 is the newest record; older ones slide down and the eighth drops out
   generate
      for (gi = 0; gi < `TC_HIST; gi = gi + 1) begin : g_hist
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               hist_q[gi] <= '0;
            end else if (err_log) begin
               if (gi == 0) begin
                  hist_q[gi] <= {16'h0000, err_mode, err_pwm, err_current, err_temp,
                                 err_speed, err_vbus, err_word};
               end else begin
                  hist_q[gi] <= hist_q[(gi == 0) ? 0 : gi - 1];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // interrupts
   // ----------------------------------------
   assign ev_done = (store & (state_q == TC_POST) & (stored_q + 9'd1 == eff_count)) |
                    (store & (state_q == TC_PRE) & fire & (fill_q == pre_n) & (fill_q + 9'd1 == eff_count)) |
                    (store & (state_q == TC_CONT) & saving_q & (stored_q + 9'd1 == eff_count));
   assign ev_trig = (store & (state_q == TC_PRE) & fire & (fill_q == pre_n)) |
                    (store & (state_q == TC_CONT) & ~saving_q & fire);
   assign ev_cfg  = start_wr & (pwdata[7:0] != 8'h00) & cfg_bad;

   always_comb begin
      ev_vec                = '0;
      ev_vec[`TC_IRQ_DONE]  = ev_done & ~start_wr;
      ev_vec[`TC_IRQ_TRIG]  = ev_trig & ~start_wr;
      ev_vec[`TC_IRQ_CFG]   = ev_cfg;
      ev_vec[`TC_IRQ_ERR]   = err_log;
   end

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_q <= '0;
      end else if (wr_en && paddr == `TC_OFF_ICLR) begin
         istat_q <= (istat_q & ~pwdata[`TC_NIRQ-1:0]) | ev_vec;
      end else begin
         istat_q <= istat_q | ev_vec;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(istat_q & ien_q);
      end
   end

endmodule : tc_capture
